//--- rtl/wake_pkg.sv
/*
 * Shared constants and carrier types for the wake signalling controller.
 * Assumes a single 100 MHz core clock and eleven general-purpose pins.
 */
package wake_pkg;

    // pin count and clock rate
    localparam int GPIO_N  = 11;
    localparam int CLK_MHZ = 100;

    // pulse lengths in microseconds, and the cycle counts derived from them
    localparam int PULSE_SHORT_US  = 50;
    localparam int PULSE_LONG_US   = 1500;
    localparam int PULSE_SHORT_CYC = PULSE_SHORT_US * CLK_MHZ;
    localparam int PULSE_LONG_CYC  = PULSE_LONG_US * CLK_MHZ;

    // pins reserved for signalling in each phy mode
    localparam int INT_WAKE_OUT_PIN = 0;
    localparam int INT_MODE_PIN     = 1;
    localparam int EXT_WAKE_OUT_PIN = 8;
    localparam int EXT_MODE_PIN     = 9;
    localparam int LINK_WAKE_PIN    = 10;

    // wake-capable pin masks and the default active-low set
    localparam logic [GPIO_N-1:0] INT_CAPABLE_MASK   = 11'h7fc;
    localparam logic [GPIO_N-1:0] EXT_CAPABLE_MASK   = 11'h400;
    localparam logic [GPIO_N-1:0] INT_LOW_ACTIVE_SET = 11'h3fc;

    // reset values of the pin registers (direction bit 1 means output)
    localparam logic [GPIO_N-1:0] DIR_RESET  = 11'h000;
    localparam logic [GPIO_N-1:0] DATA_RESET = 11'h000;

    // flag encodings
    localparam logic SIG_LEVEL      = 1'b0;
    localparam logic POL_HIGH       = 1'b1;
    localparam logic BUF_PUSH_PULL  = 1'b1;
    localparam logic NET_SRC_WOL    = 1'b0;
    localparam logic DET_ACTIVE_LOW = 1'b0;
    localparam logic PHY_EXTERNAL   = 1'b1;

    // configuration flags as delivered by the eeprom loader
    typedef struct packed {
        logic              present;         // eeprom found
        logic              self_powered;    // power method
        logic              wake_enable;     // wake_enable_flag
        logic              sig_pulse;       // 0 level, 1 pulse
        logic              pulse_long;      // pulse length select
        logic              polarity;        // 1 high active
        logic              buffer_type;     // 1 push-pull, 0 open-drain
        logic              net_source;      // network_wake_source_select
        logic              link_pin_detect; // pin 10 sense, 0 active low
        logic [GPIO_N-1:0] pin_wake_enable; // pin_wake_enable_bits default
    } eeprom_flags_s;

    // software write to the pin registers
    typedef struct packed {
        logic              wr_dir;
        logic              wr_data;
        logic              wr_wake_en;
        logic [GPIO_N-1:0] value;
    } sw_write_s;

endpackage

//--- rtl/wake_signal_controller.sv
/*
 * Wake signalling controller: watches pins and network events while the
 * device sits in wake mode, and signals the embedded controller on a
 * reserved pin. Assumes pins arrive asynchronously, network events arrive
 * on the core clock, and the eeprom flags are stable while reset is held.
 */
// How it works
// - wake signalling only when self powered
// - internal phy: pin 0 out, pin 1 select
// - external phy: pins 8 and 9 take over
// - pin wakes only as enabled input
// - reset makes inputs, loads wake enables
// - signalling pins ignore registers in wake mode
// - capable pins 2-10 internal, 10 external
// - pin 10 sense from flag, 2-9 low
// - wake packet in wake mode asserts wake
// - link partner in wake mode asserts wake
// - wake mode needs enable; flags select style
// - level 0, high 1, push-pull 1, packet 0
// - wake never shows in status registers
// - software cannot clear wake nor write pins
// - every reset in wake mode reloads configuration
// - mode select sampled when clearing reset asserted
// - power-on with select high enters wake mode
// - any enabled event signals wake output
// - bus power loss holds a bus-powered chip in reset
`timescale 1ns/1ps
module wake_signal_controller #(
    parameter int PULSE_SHORT_CYC = wake_pkg::PULSE_SHORT_CYC,
    parameter int PULSE_LONG_CYC  = wake_pkg::PULSE_LONG_CYC,
    parameter int CNT_W           = 18
) (
    // clock and power-on reset
    input  wire logic                                I_CLK,
    input  wire logic                                I_RST,
    // configuration from the eeprom loader
    input  wire wake_pkg::eeprom_flags_s             I_EEPROM,
    // pins from the embedded controller and board
    input  wire logic                                I_EXTERNAL_RESET_N,
    input  wire logic                                I_BUS_POWER_DETECT,
    input  wire logic                                I_PHY_SELECT_STRAP,
    input  wire logic [wake_pkg::GPIO_N-1:0]         I_GPIO_IN,
    // network events on the core clock
    input  wire logic                                I_WOL_PACKET,
    input  wire logic                                I_LINK_UP,
    // software access to the pin registers
    input  wire wake_pkg::sw_write_s                 I_SW_WRITE,
    // pin drivers
    output logic      [wake_pkg::GPIO_N-1:0]         O_GPIO_OUT,
    output logic      [wake_pkg::GPIO_N-1:0]         O_GPIO_OE_N,
    // status toward software and the chip
    output logic      [wake_pkg::GPIO_N-1:0]         O_GPIO_STATE,
    output logic      [wake_pkg::GPIO_N-1:0]         O_WAKE_ENABLE_BITS,
    output logic                                     O_WRITE_BLOCKED,
    output logic                                     O_WAKE_MODE,
    output logic                                     O_CHIP_RESET
);

    localparam int N    = wake_pkg::GPIO_N;
    localparam int SW   = N + 3;                        // synchronised pin count
    localparam logic [CNT_W-1:0] SHORT_CNT = CNT_W'(PULSE_SHORT_CYC);
    localparam logic [CNT_W-1:0] LONG_CNT  = CNT_W'(PULSE_LONG_CYC);

    // wake mode states
    typedef enum logic [1:0] {
        MODE_NORMAL,                                    // ordinary operation
        MODE_ARMED,                                     // waiting for an event
        MODE_SIGNALLED                                  // event seen, wake pending
    } mode_e;

    // pins that may raise a wake in the given phy mode
    function automatic logic [N-1:0] capable_mask(input logic ext);
        capable_mask = ext ? wake_pkg::EXT_CAPABLE_MASK : wake_pkg::INT_CAPABLE_MASK;
    endfunction

    // pins that detect a low level
    function automatic logic [N-1:0] low_active_set(input logic ext, input logic det);
        logic [N-1:0] m;
        m = ext ? {N{1'b0}} : wake_pkg::INT_LOW_ACTIVE_SET;
        m[wake_pkg::LINK_WAKE_PIN] = (det == wake_pkg::DET_ACTIVE_LOW);
        low_active_set = m;
    endfunction

    // synchroniser stages and filtered pin levels
    logic [SW-1:0]            sync1;                    // first stage, read by sync2 only
    logic [SW-1:0]            sync2;
    logic [SW-1:0]            sync3;
    logic [SW-1:0]            filt;                     // level once stages 2 and 3 agree
    logic                     ext_reset_n_f;
    logic                     bus_power_f;
    logic                     phy_strap_f;
    logic [N-1:0]             gpio_f;

    // configuration and mode
    wake_pkg::eeprom_flags_s  cfg;                      // latched eeprom flags
    logic                     phy_external;             // latched phy strap
    mode_e                    mode;
    mode_e                    next_mode;
    logic                     chip_rst;                 // internal reset, any source
    logic                     unpowered;
    logic                     mode_pin_now;             // select pin during reset

    // pin registers owned by software
    logic [N-1:0]             gpio_dir;
    logic [N-1:0]             gpio_data;
    logic [N-1:0]             wake_en;

    // events and signalling
    logic [N-1:0]             pin_hit;
    logic                     pin_event;
    logic                     net_event;
    logic                     any_event;
    logic [CNT_W-1:0]         pulse_cnt;
    logic                     signalling;
    logic                     wake_level;
    int                       out_pin;
    int                       mode_pin;
    logic [N-1:0]             next_gpio_out;
    logic [N-1:0]             next_gpio_oe_n;

    // three-stage synchroniser; stages carry no reset so a select pin
    // sampled during power-on reset already holds its real level
    always_ff @(posedge I_CLK) begin
        sync1 <= {I_EXTERNAL_RESET_N, I_BUS_POWER_DETECT, I_PHY_SELECT_STRAP, I_GPIO_IN};
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // a change counts only once the second and third stages agree
    always_ff @(posedge I_CLK) begin
        filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
    end

    assign ext_reset_n_f = filt[SW-1];
    assign bus_power_f   = filt[SW-2];
    assign phy_strap_f   = filt[SW-3];
    assign gpio_f        = filt[N-1:0];

    // bus power gone on a bus-powered device holds the whole chip in reset;
    // the external reset is then irrelevant because reset is already held
    assign unpowered = !cfg.self_powered && !bus_power_f;
    assign chip_rst  = I_RST || !ext_reset_n_f || unpowered;

    // configuration and strap reload on every reset, wake mode or not
    always_ff @(posedge I_CLK) begin
        if (chip_rst) begin
            cfg          <= I_EEPROM;
            phy_external <= (phy_strap_f == wake_pkg::PHY_EXTERNAL);
        end
    end

    // select pin read while reset is held, from the strap's own mode
    assign mode_pin_now = (phy_strap_f == wake_pkg::PHY_EXTERNAL) ?
                          gpio_f[wake_pkg::EXT_MODE_PIN] :
                          gpio_f[wake_pkg::INT_MODE_PIN];

    // pin role selection for the running mode
    assign out_pin  = phy_external ? wake_pkg::EXT_WAKE_OUT_PIN : wake_pkg::INT_WAKE_OUT_PIN;
    assign mode_pin = phy_external ? wake_pkg::EXT_MODE_PIN : wake_pkg::INT_MODE_PIN;

    // pin events: enabled, configured as input, capable, at its active level
    always_comb begin
        pin_hit = (gpio_f ^ low_active_set(phy_external, cfg.link_pin_detect))
                & capable_mask(phy_external)
                & wake_en & ~gpio_dir;
    end
    assign pin_event = |pin_hit;

    // the network source flag chooses packet or link partner as the event
    assign net_event = (cfg.net_source == wake_pkg::NET_SRC_WOL) ?
                       I_WOL_PACKET :
                       I_LINK_UP;
    assign any_event = pin_event || net_event;

    // mode sequencing; only a reset leaves wake mode, so software has no
    // way to clear a pending wake
    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_NORMAL: begin
                next_mode = MODE_NORMAL;
            end
            MODE_ARMED: begin
                if (any_event) begin
                    next_mode = MODE_SIGNALLED;
                end
            end
            MODE_SIGNALLED: begin
                next_mode = MODE_SIGNALLED;
            end
            default: begin
                next_mode = MODE_NORMAL;
            end
        endcase
    end

    // the clearing reset samples the select pin: 1 stays in wake mode,
    // 0 resumes; entry also needs eeprom, enable flag and self power
    always_ff @(posedge I_CLK) begin
        if (chip_rst) begin
            if (I_EEPROM.present && I_EEPROM.wake_enable &&
                I_EEPROM.self_powered && mode_pin_now) begin
                mode <= MODE_ARMED;
            end else begin
                mode <= MODE_NORMAL;
            end
        end else begin
            mode <= next_mode;
        end
    end

    // pulse timer, loaded on the event that enters the signalled state
    always_ff @(posedge I_CLK) begin
        if (chip_rst) begin
            pulse_cnt <= '0;
        end else if (mode == MODE_ARMED && next_mode == MODE_SIGNALLED) begin
            pulse_cnt <= cfg.pulse_long ? LONG_CNT : SHORT_CNT;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - CNT_W'(1);
        end
    end

    // level style holds until reset, pulse style only while the timer runs
    assign signalling = (mode == MODE_SIGNALLED) &&
                        ((cfg.sig_pulse == wake_pkg::SIG_LEVEL) || pulse_cnt != '0);
    assign wake_level = signalling ? cfg.polarity : !cfg.polarity;

    // software pin registers; writes are dropped in wake mode, and a
    // reset makes every pin an input and reloads the wake enables
    always_ff @(posedge I_CLK) begin
        if (chip_rst) begin
            gpio_dir  <= wake_pkg::DIR_RESET;
            gpio_data <= wake_pkg::DATA_RESET;
            wake_en   <= I_EEPROM.pin_wake_enable;
        end else if (mode == MODE_NORMAL) begin
            if (I_SW_WRITE.wr_dir) begin
                gpio_dir <= I_SW_WRITE.value;
            end
            if (I_SW_WRITE.wr_data) begin
                gpio_data <= I_SW_WRITE.value;
            end
            if (I_SW_WRITE.wr_wake_en) begin
                wake_en <= I_SW_WRITE.value;
            end
        end
    end

    // pin drive: register values normally, signalling roles in wake mode
    always_comb begin
        next_gpio_out  = gpio_data;
        next_gpio_oe_n = ~gpio_dir;
        if (mode != MODE_NORMAL) begin
            next_gpio_out[mode_pin]  = 1'b0;
            next_gpio_oe_n[mode_pin] = 1'b1;
            if (!cfg.self_powered) begin
                next_gpio_out[out_pin]  = 1'b0;
                next_gpio_oe_n[out_pin] = 1'b1;
            end else if (cfg.buffer_type == wake_pkg::BUF_PUSH_PULL) begin
                next_gpio_out[out_pin]  = wake_level;
                next_gpio_oe_n[out_pin] = 1'b0;
            end else begin
                // open-drain pulls low only; the high level comes from a pull-up
                next_gpio_out[out_pin]  = 1'b0;
                next_gpio_oe_n[out_pin] = wake_level;
            end
        end
    end

    // registered pin drivers; a reset releases every pin
    always_ff @(posedge I_CLK) begin
        if (chip_rst) begin
            O_GPIO_OUT  <= wake_pkg::DATA_RESET;
            O_GPIO_OE_N <= ~wake_pkg::DIR_RESET;
        end else begin
            O_GPIO_OUT  <= next_gpio_out;
            O_GPIO_OE_N <= next_gpio_oe_n;
        end
    end

    // status toward software shows pin levels and registers only; the
    // wake mode and its events leave no trace there
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_GPIO_STATE       <= '0;
            O_WAKE_ENABLE_BITS <= '0;
            O_CHIP_RESET       <= 1'b1;
        end else begin
            O_GPIO_STATE       <= gpio_f;
            O_WAKE_ENABLE_BITS <= wake_en;
            O_CHIP_RESET       <= chip_rst;
        end
    end

    // mode indications for the rest of the chip, not for software status
    assign O_WAKE_MODE     = (mode != MODE_NORMAL);
    assign O_WRITE_BLOCKED = (mode != MODE_NORMAL);

    // checks
    bus_power_nowake_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !cfg.self_powered && !chip_rst |-> mode == MODE_NORMAL)
        else $error("wake mode active while bus powered");

    select_pin_input_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        mode != MODE_NORMAL && !chip_rst |=> O_GPIO_OE_N[$past(mode_pin)])
        else $error("mode select pin driven in wake mode");

    reset_inputs_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        chip_rst |=> gpio_dir == '0 && wake_en == $past(I_EEPROM.pin_wake_enable))
        else $error("reset did not restore pin registers");

    ext_capable_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        phy_external |-> pin_hit[N-2:0] == '0)
        else $error("non-capable pin raised an event");

    event_signals_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        mode == MODE_ARMED && any_event && !chip_rst |=> mode == MODE_SIGNALLED)
        else $error("enabled event did not signal wake");

    writes_blocked_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        mode != MODE_NORMAL && !chip_rst ##1 !chip_rst |-> $stable(gpio_dir) && $stable(wake_en))
        else $error("pin register changed in wake mode");

    config_reload_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        chip_rst |=> cfg == $past(I_EEPROM))
        else $error("configuration not reloaded on reset");

    level_holds_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        mode == MODE_SIGNALLED && cfg.sig_pulse == wake_pkg::SIG_LEVEL && !chip_rst
        ##1 !chip_rst |-> (cfg.buffer_type == wake_pkg::BUF_PUSH_PULL) ?
        (O_GPIO_OUT[out_pin] == cfg.polarity && !O_GPIO_OE_N[out_pin]) :
        (O_GPIO_OE_N[out_pin] == cfg.polarity && !O_GPIO_OUT[out_pin]))
        else $error("level wake not held");

    pulse_load_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        mode == MODE_ARMED && any_event && !chip_rst && cfg.pulse_long && cfg.sig_pulse
        |=> pulse_cnt == LONG_CNT ##1 pulse_cnt == LONG_CNT - CNT_W'(1))
        else $error("pulse length not loaded");

    open_drain_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        mode != MODE_NORMAL && cfg.buffer_type != wake_pkg::BUF_PUSH_PULL && !chip_rst
        |=> !(O_GPIO_OE_N[out_pin] == 1'b0 && O_GPIO_OUT[out_pin] == 1'b1))
        else $error("open-drain pin driven high");

    enter_wake_c: cover property (@(posedge I_CLK) disable iff (I_RST)
        chip_rst ##1 mode == MODE_ARMED);
    pin_wake_c: cover property (@(posedge I_CLK) disable iff (I_RST)
        mode == MODE_ARMED && pin_event ##1 mode == MODE_SIGNALLED);
    net_wake_c: cover property (@(posedge I_CLK) disable iff (I_RST)
        mode == MODE_ARMED && net_event ##1 mode == MODE_SIGNALLED);
    resume_c: cover property (@(posedge I_CLK) disable iff (I_RST)
        mode == MODE_SIGNALLED ##1 chip_rst ##1 mode == MODE_NORMAL);

endmodule // wake_signal_controller

//--- verif/embedded_controller_model.sv
/*
 * Behavioural model of the embedded controller that waits for the wake pin.
 * Assumes the bench hands it the resolved wake line, the configured polarity,
 * and whether the device should stay in wake mode after the clear.
 */
`timescale 1ns/1ps
module embedded_controller_model (
    // clock
    input  wire logic       i_clk,
    // bench control
    input  wire logic       i_arm,
    input  wire logic       i_stay,
    input  wire logic       i_power,
    input  wire logic [7:0] i_delay,
    // device side
    input  wire logic       i_wake_line,
    input  wire logic       i_pol,
    output logic            o_reset_n,
    output logic            o_bus_power,
    output logic            o_select,
    output logic      [7:0] o_clears
);
    // one process: idle follows the bench, a seen wake runs the clear sequence
    initial begin
        o_reset_n   = 1'b1;
        o_bus_power = 1'b1;
        o_select    = 1'b1;
        o_clears    = 8'h00;
        forever begin
            @(posedge i_clk);
            if (i_arm && i_wake_line === i_pol) begin
                // slow answer on purpose, so level and pulse shapes stay visible
                repeat (i_delay) @(posedge i_clk);
                o_bus_power <= 1'b1;
                repeat (4) @(posedge i_clk);
                o_select <= i_stay;
                repeat (6) @(posedge i_clk);
                o_reset_n <= 1'b0;
                repeat (10) @(posedge i_clk);
                o_reset_n <= 1'b1;
                repeat (10) @(posedge i_clk);
                o_clears <= o_clears + 8'h01;
            end else begin
                // host is off by default: select high keeps wake mode
                o_bus_power <= i_power;
                o_select    <= 1'b1;
            end
        end
    end
endmodule // embedded_controller_model

//--- verif/testbench.sv
/*
 * Self-checking bench for the wake signalling controller.
 * Assumes pins are pulled up when released and pulse counts are shortened.
 */
`timescale 1ns/1ps
module testbench;
    localparam int PS = 8;   // short pulse in sim
    localparam int PL = 20;  // long pulse in sim
    logic                    clk = 1'b0;
    logic                    rst, strap, wol, link, sel, rst_n, bus_pwr;
    logic                    arm, stay, power, blocked, wmode, chip_rst;
    logic [7:0]              delay, clears;
    logic [10:0]             base, gin, gout, goe_n, gstate, wen;
    wake_pkg::eeprom_flags_s ee;
    wake_pkg::sw_write_s     sw;
    int                      seed = 32'h4815_82a3;
    int                      fail_count = 0;
    int                      tests_run = 0;
    // pull-up on every pad; device drives only where enable is low
    wire logic [10:0] pad = (~goe_n & gout) | goe_n;

    always #5 clk = ~clk;
    // select pin comes from the controller model
    always_comb begin
        gin = base;
        gin[strap ? 9 : 1] = sel;
    end

    wake_signal_controller #(.PULSE_SHORT_CYC(PS), .PULSE_LONG_CYC(PL)) dut (
        .I_CLK(clk), .I_RST(rst), .I_EEPROM(ee), .I_EXTERNAL_RESET_N(rst_n),
        .I_BUS_POWER_DETECT(bus_pwr), .I_PHY_SELECT_STRAP(strap), .I_GPIO_IN(gin),
        .I_WOL_PACKET(wol), .I_LINK_UP(link), .I_SW_WRITE(sw), .O_GPIO_OUT(gout),
        .O_GPIO_OE_N(goe_n), .O_GPIO_STATE(gstate), .O_WAKE_ENABLE_BITS(wen),
        .O_WRITE_BLOCKED(blocked), .O_WAKE_MODE(wmode), .O_CHIP_RESET(chip_rst));
    embedded_controller_model ctrl (
        .i_clk(clk), .i_arm(arm), .i_stay(stay), .i_power(power), .i_delay(delay),
        .i_wake_line(pad[strap ? 8 : 0]), .i_pol(ee.polarity), .o_reset_n(rst_n),
        .o_bus_power(bus_pwr), .o_select(sel), .o_clears(clears));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // expected {enable_n, data} of the wake pin, idle or active
    function automatic logic [1:0] pin_exp(input logic act);
        if (ee.buffer_type) return {1'b0, act ? ee.polarity : ~ee.polarity};
        // open drain: released for the high level, pulled low for the low level
        return {act ? ee.polarity : ~ee.polarity, 1'b0};
    endfunction

    function automatic logic [1:0] pin_now(input int i);
        return {goe_n[i], gout[i]};
    endfunction

    task automatic por();
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
    endtask

    // normal mode: writes land, network events do nothing
    task automatic normal_trial();
        logic [10:0] v, d, w;
        ee = 20'($random(seed));
        ee.wake_enable = 1'b0;
        ee.self_powered = 1'b1;
        v = 11'($random(seed));
        d = 11'($random(seed));
        w = 11'($random(seed));
        por();
        check(wmode, 1'b0);
        check(goe_n, 11'h7ff);
        check(wen, ee.pin_wake_enable);
        sw = {3'b100, v};
        @(negedge clk);
        sw = {3'b010, d};
        @(negedge clk);
        sw = {3'b001, w};
        @(negedge clk);
        sw = '0;
        link = 1'b1;
        wol = 1'b1;
        repeat (8) @(negedge clk);
        check(goe_n, ~v);
        check(gout, d);
        check(wmode, 1'b0);
        check(gstate, gin);
        check(wen, w);
        link = 1'b0;
        wol = 1'b0;
    endtask

    // bus powered: no wake mode, power loss holds the chip in reset
    task automatic bus_trial();
        ee.self_powered = 1'b0;
        ee.wake_enable = 1'b1;
        ee.present = 1'b1;
        por();
        check(wmode, 1'b0);
        power = 1'b0;
        repeat (8) @(negedge clk);
        check(chip_rst, 1'b1);
        power = 1'b1;
        repeat (8) @(negedge clk);
        check(chip_rst, 1'b0);
    endtask

    // wake mode: decoy event, real event, signal shape, controller clear
    task automatic wake_trial(input bit use_pin);
        logic [10:0] oe_before;
        logic [7:0]  c;
        int op, p, q, n;
        ee = 20'($random(seed));
        {ee.present, ee.self_powered, ee.wake_enable} = 3'b111;
        strap = 1'($random(seed));
        op = strap ? 8 : 0;
        p = strap ? 10 : 2 + {$random(seed)} % 9;
        q = strap ? 5 : ((p == 2) ? 3 : 2);
        ee.pin_wake_enable[p] = 1'b1;
        ee.pin_wake_enable[q] = strap; // external: enabled but not capable
        base = {~ee.link_pin_detect, 10'h3ff};
        delay = 8'(35 + {$random(seed)} % 60);
        stay = 1'($random(seed));
        power = 1'b0;
        por();
        arm = 1'b1;
        check(wmode, 1'b1);
        check(blocked, 1'b1);
        check(goe_n[strap ? 9 : 1], 1'b1);
        check(pin_now(op), pin_exp(1'b0));
        oe_before = goe_n;
        sw = {3'b111, 11'h7ff};
        @(negedge clk);
        sw = '0;
        if (use_pin) base[q] = 1'b0;
        else if (ee.net_source) wol = 1'b1;
        else link = 1'b1;
        repeat (8) @(negedge clk);
        check(goe_n, oe_before);
        check(wen, ee.pin_wake_enable);
        check(pin_now(op), pin_exp(1'b0));
        check(gstate, gin);
        base[q] = 1'b1;
        wol = 1'b0;
        link = 1'b0;
        if (use_pin) base[p] = (p == 10) ? ee.link_pin_detect : 1'b0;
        else if (ee.net_source) link = 1'b1;
        else wol = 1'b1;
        n = 0;
        while (pin_now(op) !== pin_exp(1'b1) && n < 12) begin
            @(negedge clk);
            n++;
        end
        check(n < 12, 1);
        base = {~ee.link_pin_detect, 10'h3ff};
        wol = 1'b0;
        link = 1'b0;
        n = 0;
        while (pin_now(op) === pin_exp(1'b1) && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(n, ee.sig_pulse ? (ee.pulse_long ? PL : PS) : 40);
        c = clears;
        n = 0;
        while (clears === c && n < 300) begin
            @(negedge clk);
            n++;
        end
        arm = 1'b0;
        check(wmode, stay);
        check(wen, ee.pin_wake_enable);
    endtask

    // watchdog far beyond the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        {rst, strap, wol, link, arm, stay, power} = 7'b1000001;
        ee = '0;
        sw = '0;
        base = 11'h7ff;
        delay = 8'h28;
        normal_trial();
        bus_trial();
        for (int i = 0; i < 12; i++) wake_trial(i[0]);
        report_and_stop();
    end
endmodule // testbench
